// File: logic/sccg_defs.svh
// constants for the serial channel clock generator
`ifndef SCCG_DEFS_SVH
`define SCCG_DEFS_SVH

`define SCCG_NUM_CH           3
`define SCCG_ADDR_W           8
`define SCCG_CH_FIELD_LSB     4
`define SCCG_OFS_CONTROL      4'h0
`define SCCG_OFS_BAUD_CTRL    4'h4
`define SCCG_OFS_BAUD_FRAC    4'h8
`define SCCG_OFS_STATUS       4'hc
`define SCCG_OFS_GEAR         8'h30

`define SCCG_CTL_W            7
`define SCCG_CTL_MODE_LSB     0
`define SCCG_CTL_DIR_BIT      2
`define SCCG_CTL_EDGE_BIT     3
`define SCCG_CTL_SRC_LSB      4
`define SCCG_CTL_PARITY_BIT   6
`define SCCG_CTL_RESET        7'h00

`define SCCG_BRC_W            7
`define SCCG_BRC_N_LSB        0
`define SCCG_BRC_TAP_LSB      4
`define SCCG_BRC_FRAC_BIT     6
`define SCCG_BRC_RESET        7'h01
`define SCCG_K_RESET          4'h0
`define SCCG_GEAR_RESET       4'h0
`define SCCG_GEAR_FS_BIT      3
`define SCCG_STATUS_FAST_BIT  4
`define SCCG_STATUS_W         5

`define SCCG_ASYNC_OVERSAMPLE 16
`define SCCG_EXT_ASYNC_MIN    5'd4
`define SCCG_EXT_SYNC_MIN     5'd16

`endif

// File: logic/sccg_pkg.sv
// types shared by the serial channel clock generator
package sccg_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART7,
    MODE_UART8,
    MODE_UART9
  } serial_mode_t;

  typedef enum logic [1:0] {
    SRC_BAUD,
    SRC_SYSCLK,
    SRC_TIMER,
    SRC_PIN
  } clock_src_t;

endpackage : sccg_pkg

// File: logic/baud_divider.sv
// integer or n + (16-k)/16 divider on prescaler tap ticks
module baud_divider
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       run_in,
  input  wire logic       tap_tick_in,
  input  wire logic [3:0] integer_divisor_n_in,
  input  wire logic [3:0] fractional_term_k_in,
  input  wire logic       fractional_in,
  output logic            tick_out
);

  logic [4:0] n_eff;
  logic [4:0] last;
  logic [4:0] step;
  logic [4:0] acc_sum;
  logic [4:0] cnt_q;
  logic [3:0] acc_q;
  logic       ext_q;

  // a zero field means divide by sixteen
  assign n_eff = (integer_divisor_n_in == 4'h0) ? 5'd16
               : {1'b0, integer_divisor_n_in};
  assign last = n_eff - 5'd1 + {4'b0, ext_q};
  assign step = 5'd16 - {1'b0, fractional_term_k_in};
  assign acc_sum = {1'b0, acc_q} + step;

  always_ff @(posedge clk_in)
  begin
    if (srst_in || !run_in)
    begin
      cnt_q <= 5'd0;
      acc_q <= 4'h0;
      ext_q <= 1'b0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (tap_tick_in)
      begin
        if (cnt_q >= last)
        begin
          cnt_q <= 5'd0;
          tick_out <= 1'b1;
          // carry lengthens the next period by one tap
          if (fractional_in)
          begin
            acc_q <= acc_sum[3:0];
            ext_q <= acc_sum[4];
          end
          else
          begin
            acc_q <= 4'h0;
            ext_q <= 1'b0;
          end
        end
        else
        begin
          cnt_q <= cnt_q + 5'd1;
        end
      end
    end
  end

endmodule : baud_divider

// File: logic/shift_clock_edge.sv
// edge detection and period check on the serial clock pin
module shift_clock_edge
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       pin_in,
  input  wire logic       falling_in,
  input  wire logic [4:0] min_period_in,
  output logic            edge_out,
  output logic            too_fast_out
);

  logic       prev_q;
  logic [4:0] since_q;
  logic       rise;
  logic       fall;

  assign rise = pin_in && !prev_q;
  assign fall = !pin_in && prev_q;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      prev_q <= 1'b1;
      since_q <= 5'h1f;
      edge_out <= 1'b0;
      too_fast_out <= 1'b0;
    end
    else
    begin
      prev_q <= pin_in;
      edge_out <= falling_in ? fall : rise;
      // period measured rising to rising in system cycles
      // widened so a saturated count cannot wrap to zero
      too_fast_out <= rise &&
                      (6'(since_q) + 6'd1 < 6'(min_period_in));
      if (rise)
        since_q <= 5'd0;
      else if (since_q != 5'h1f)
        since_q <= since_q + 5'd1;
    end
  end

endmodule : shift_clock_edge

// File: logic/serial_channel_clock_gen.sv
// transfer clock generation for the serial channels, apb registers
`include "sccg_defs.svh"

// Operation
// - three identical independent channels
// - shift mode plus 7/8/9-bit uart modes
// - parity allowed only in 7/8-bit modes
// - ninth bit marks address when set
// - prescaler runs only when baud generator used
// - tap select 4/16/64/256, scaled by gear
// - fraction off: divide tap by integer n
// - fraction on: divide by n+(16-k)/16
// - uart rate /16, shift rate /2
// - external uart clock /16, period ≥4 cycles
// - external shift clock direct, period ≥16 cycles
// - timer trigger clocks uart only
// - shift output: basic clock is generator/2
// - shift input: basic clock from chosen edge
// - uart source: baud, sysclk, timer, pin
module serial_channel_clock_gen
#(
  parameter int NUM_CH = `SCCG_NUM_CH
)
(
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic              timer_zero_match_trigger_in,
  input  wire logic [NUM_CH-1:0] serial_clock_pin_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [31:0]            prdata_out,
  output logic [NUM_CH-1:0]      serial_clock_pin_out,
  output logic [NUM_CH-1:0]      serial_clock_pin_oe_n_out,
  output logic [NUM_CH-1:0]      basic_sampling_clock_out,
  output logic [NUM_CH-1:0]      bit_clock_out
);

  logic [3:0]        gear_q;
  logic [3:0]        gear_cnt_q;
  logic [4:0]        gear_last;
  logic              gear_tick;
  logic [7:0]        presc_q;
  logic [3:0]        tap_q;
  logic [NUM_CH-1:0] uses_baud;
  logic              presc_run;
  logic              access;
  logic              commit;
  logic              wr_commit;
  logic              mapped;
  logic [31:0]       rd_word;
  logic [31:0]       ch_rd [NUM_CH];
  logic [NUM_CH-1:0] ch_hit;

  // apb: one wait state, pready and data both registered
  assign access = psel_in && penable_in;
  assign commit = access && pready_out;
  assign wr_commit = commit && pwrite_in;

  always_comb
  begin
    mapped = (paddr_in == `SCCG_OFS_GEAR) || (|ch_hit);
    rd_word = 32'h0000_0000;
    if (paddr_in == `SCCG_OFS_GEAR)
      rd_word = {28'h000_0000, gear_q};
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (ch_hit[i])
        rd_word = ch_rd[i];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else
    begin
      pready_out <= access && !pready_out;
      pslverr_out <= access && !pready_out && !mapped;
      if (access && !pready_out && !pwrite_in)
        prdata_out <= rd_word;
      else
        prdata_out <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      gear_q <= `SCCG_GEAR_RESET;
    else if (wr_commit && paddr_in == `SCCG_OFS_GEAR)
      gear_q <= pwdata_in[3:0];
  end

  // gear ratio 1,2,4,8,16; fs bit bypasses the gear
  always_comb
  begin
    gear_last = 5'd0;
    if (!gear_q[`SCCG_GEAR_FS_BIT])
    begin
      unique case (gear_q[2:0])
        3'd0:    gear_last = 5'd0;
        3'd1:    gear_last = 5'd1;
        3'd2:    gear_last = 5'd3;
        3'd3:    gear_last = 5'd7;
        default: gear_last = 5'd15;
      endcase
    end
  end

  assign presc_run = |uses_baud;
  assign gear_tick = ({1'b0, gear_cnt_q} >= gear_last);

  // gear stage (/1 to /16) feeding the 8-bit prescaler, taps as pulses
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !presc_run)
    begin
      gear_cnt_q <= 4'h0;
      presc_q <= 8'h00;
      tap_q <= 4'h0;
    end
    else
    begin
      gear_cnt_q <= gear_tick ? 4'h0 : gear_cnt_q + 4'h1;
      if (gear_tick)
        presc_q <= presc_q + 8'h01;
      tap_q[0] <= gear_tick && (&presc_q[1:0]);
      tap_q[1] <= gear_tick && (&presc_q[3:0]);
      tap_q[2] <= gear_tick && (&presc_q[5:0]);
      tap_q[3] <= gear_tick && (&presc_q[7:0]);
    end
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [`SCCG_CTL_W-1:0] ctl_q;
    logic [`SCCG_BRC_W-1:0] brc_q;
    logic [3:0]             k_q;
    logic                   fast_q;
    logic                   sclk_q;
    logic [3:0]             os_q;
    logic                   is_sync;
    logic                   dir_in;
    logic                   frac_on;
    logic                   parity_on;
    logic                   nine_bit;
    logic                   baud_tick;
    logic                   ext_tick;
    logic                   too_fast;
    logic                   basic_d;
    logic                   sel;
    logic [1:0]             tap_sel;
    sccg_pkg::serial_mode_t mode;
    sccg_pkg::clock_src_t   src;

    assign sel = (paddr_in[7:4] == 4'(c)) &&
                 (paddr_in[1:0] == 2'b00);
    assign ch_hit[c] = sel;
    assign mode = sccg_pkg::serial_mode_t'(ctl_q[1:0]);
    assign src = sccg_pkg::clock_src_t'(ctl_q[5:4]);
    assign is_sync = (mode == sccg_pkg::MODE_SHIFT);
    assign dir_in = ctl_q[`SCCG_CTL_DIR_BIT];
    assign tap_sel = brc_q[5:4];
    assign parity_on = ctl_q[`SCCG_CTL_PARITY_BIT] &&
                       (mode == sccg_pkg::MODE_UART7 ||
                        mode == sccg_pkg::MODE_UART8);
    // ninth bit carries the address/data mark
    assign nine_bit = (mode == sccg_pkg::MODE_UART9);
    // fraction is never applied in shift mode
    assign frac_on = brc_q[`SCCG_BRC_FRAC_BIT] && !is_sync;
    assign uses_baud[c] = is_sync ? !dir_in
                        : (src == sccg_pkg::SRC_BAUD);

    always_ff @(posedge clk_in)
    begin
      if (srst_in)
      begin
        ctl_q <= `SCCG_CTL_RESET;
        brc_q <= `SCCG_BRC_RESET;
        k_q <= `SCCG_K_RESET;
      end
      else if (wr_commit && sel)
      begin
        unique case (paddr_in[3:0])
          `SCCG_OFS_CONTROL:   ctl_q <= pwdata_in[6:0];
          `SCCG_OFS_BAUD_CTRL: brc_q <= pwdata_in[6:0];
          `SCCG_OFS_BAUD_FRAC: k_q <= pwdata_in[3:0];
          default:             ;
        endcase
      end
    end

    // sticky external clock period violation, write one to clear
    always_ff @(posedge clk_in)
    begin
      if (srst_in)
        fast_q <= 1'b0;
      else if (too_fast && !uses_baud[c])
        fast_q <= 1'b1;
      else if (wr_commit && sel && paddr_in[3:0] == `SCCG_OFS_STATUS
               && pwdata_in[`SCCG_STATUS_FAST_BIT])
        fast_q <= 1'b0;
    end

    always_comb
    begin
      ch_rd[c] = 32'h0000_0000;
      unique case (paddr_in[3:0])
        `SCCG_OFS_CONTROL:   ch_rd[c] = {25'h0, ctl_q};
        `SCCG_OFS_BAUD_CTRL: ch_rd[c] = {25'h0, brc_q};
        `SCCG_OFS_BAUD_FRAC: ch_rd[c] = {28'h0, k_q};
        `SCCG_OFS_STATUS:
          ch_rd[c] = {27'h0, fast_q, nine_bit, parity_on,
                      frac_on, presc_run};
        default:             ch_rd[c] = 32'h0000_0000;
      endcase
    end

    baud_divider u_div
    (
      .clk_in               (clk_in),
      .srst_in              (srst_in),
      .run_in               (uses_baud[c]),
      .tap_tick_in          (tap_q[tap_sel]),
      .integer_divisor_n_in (brc_q[3:0]),
      .fractional_term_k_in (k_q),
      .fractional_in        (frac_on),
      .tick_out             (baud_tick)
    );

    shift_clock_edge u_edge
    (
      .clk_in        (clk_in),
      .srst_in       (srst_in),
      .pin_in        (serial_clock_pin_in[c]),
      .falling_in    (is_sync && ctl_q[`SCCG_CTL_EDGE_BIT]),
      .min_period_in (is_sync ? `SCCG_EXT_SYNC_MIN
                              : `SCCG_EXT_ASYNC_MIN),
      .edge_out      (ext_tick),
      .too_fast_out  (too_fast)
    );

    // basic clock source per mode
    always_comb
    begin
      basic_d = 1'b0;
      if (is_sync)
      begin
        if (dir_in)
          basic_d = ext_tick;
        else
          basic_d = baud_tick && !sclk_q;
      end
      else
      begin
        unique case (src)
          sccg_pkg::SRC_BAUD:   basic_d = baud_tick;
          sccg_pkg::SRC_SYSCLK: basic_d = 1'b1;
          sccg_pkg::SRC_TIMER:
            basic_d = timer_zero_match_trigger_in;
          sccg_pkg::SRC_PIN:    basic_d = ext_tick;
        endcase
      end
    end

    // shift clock out toggles each generator tick, idles high
    always_ff @(posedge clk_in)
    begin
      if (srst_in || !is_sync || dir_in)
        sclk_q <= 1'b1;
      else if (baud_tick)
        sclk_q <= ~sclk_q;
    end

    always_ff @(posedge clk_in)
    begin
      if (srst_in)
      begin
        os_q <= 4'h0;
        basic_sampling_clock_out[c] <= 1'b0;
        bit_clock_out[c] <= 1'b0;
        serial_clock_pin_out[c] <= 1'b1;
        serial_clock_pin_oe_n_out[c] <= 1'b1;
      end
      else
      begin
        basic_sampling_clock_out[c] <= basic_d;
        serial_clock_pin_out[c] <= sclk_q;
        serial_clock_pin_oe_n_out[c] <= !(is_sync && !dir_in);
        if (is_sync)
        begin
          os_q <= 4'h0;
          bit_clock_out[c] <= basic_d;
        end
        else
        begin
          if (basic_d)
            os_q <= os_q + 4'h1;
          bit_clock_out[c] <= basic_d && (&os_q);
        end
      end
    end
  end

endmodule : serial_channel_clock_gen

// File: test/serial_peer.sv
// serial peer model on one channel clock pin
module serial_peer
(
  input  wire logic clk_in,
  input  wire logic oe_n_in,
  input  wire logic drv_in,
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic own_q = 1'b1;
  // the device drive wins while it holds the pin
  assign pin_out = oe_n_in ? own_q : drv_in;
  // one burst of low-then-high periods, idle high between bursts
  task automatic run(input int half, input int n);
    repeat (n)
    begin
      own_q <= 1'b0;
      repeat (half) @(posedge clk_in);
      own_q <= 1'b1;
      repeat (half) @(posedge clk_in);
    end
  endtask : run
endmodule : serial_peer

// File: test/serial_channel_clock_gen_monitor.sv
// port checker for the serial channel clock generator
module serial_channel_clock_gen_monitor
#(
  parameter int NUM_CH = 3
)
(
  input wire logic              clk_in,
  input wire logic              srst_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [7:0]        paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic              timer_zero_match_trigger_in,
  input wire logic [NUM_CH-1:0] serial_clock_pin_in,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic [31:0]       prdata_out,
  input wire logic [NUM_CH-1:0] serial_clock_pin_out,
  input wire logic [NUM_CH-1:0] serial_clock_pin_oe_n_out,
  input wire logic [NUM_CH-1:0] basic_sampling_clock_out,
  input wire logic [NUM_CH-1:0] bit_clock_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  a_ready_wait: assert property (
    $rose(penable_in) && psel_in |=> pready_out)
    else $error("no ready after one wait state");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (
    pready_out |-> $past(psel_in && penable_in))
    else $error("ready without access");
  a_error_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_data_idle: assert property (
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside ready");
  a_unmapped_err: assert property (
    $rose(penable_in) && psel_in && paddr_in >= 8'h40 |=> pslverr_out)
    else $error("unmapped access not refused");
  a_reset_idle: assert property (
    $fell(srst_in) |-> &serial_clock_pin_oe_n_out
      && basic_sampling_clock_out == '0 && bit_clock_out == '0)
    else $error("outputs not idle after reset");
  a_bit_isolated: assert property (
    (bit_clock_out & $past(bit_clock_out)) == '0)
    else $error("bit pulse on two cycles");
  a_shift_basic: assert property (
    !serial_clock_pin_oe_n_out[0] && basic_sampling_clock_out[0]
      |=> $rose(serial_clock_pin_out[0]))
    else $error("shift clock not rising after basic pulse");

  c_bit: cover property (bit_clock_out[0]);
  c_error: cover property (pslverr_out);
  c_shift: cover property ($fell(serial_clock_pin_out[0]));
endmodule : serial_channel_clock_gen_monitor

bind serial_channel_clock_gen serial_channel_clock_gen_monitor
  #(.NUM_CH(NUM_CH)) mon
  (
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .timer_zero_match_trigger_in(timer_zero_match_trigger_in),
    .serial_clock_pin_in(serial_clock_pin_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe_n_out(serial_clock_pin_oe_n_out),
    .basic_sampling_clock_out(basic_sampling_clock_out),
    .bit_clock_out(bit_clock_out)
  );

// File: test/test_serial_channel_clock_gen.sv
// self-checking bench for the serial channel clock generator
module test_serial_channel_clock_gen;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        tmr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_q;
  logic        pready, pslverr, err_q;
  logic [2:0]  pin_in, pin_out, oe_n, basic, bitc;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t;
  int          bcnt[3];
  int          kcnt[3];
  logic [7:0]  bcv[7] = '{8'h01, 8'h05, 8'h00, 8'h12, 8'h21, 8'h33, 8'h15};
  int          bsp[7] = '{16, 80, 256, 128, 256, 3072, 320};
  logic [7:0]  pv[3] = '{8'h51, 8'h53, 8'h40};
  int          pe[3] = '{1, 2, 0};

  serial_channel_clock_gen #(.NUM_CH(3)) dut
  (
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .timer_zero_match_trigger_in(tmr),
    .serial_clock_pin_in(pin_in), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata),
    .serial_clock_pin_out(pin_out), .serial_clock_pin_oe_n_out(oe_n),
    .basic_sampling_clock_out(basic), .bit_clock_out(bitc)
  );

  for (genvar i = 0; i < 3; i++)
  begin : g
    serial_peer peer
    (
      .clk_in(clk_in), .oe_n_in(oe_n[i]), .drv_in(pin_out[i]),
      .pin_out(pin_in[i])
    );
  end

  initial
  begin
    forever #4 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // pulses are one full cycle, so the falling edge counts each once
  always @(negedge clk_in)
  begin
    foreach (bcnt[i])
    begin
      bcnt[i] += basic[i];
      kcnt[i] += bitc[i];
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do
      @(posedge clk_in);
    while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_q, e);
  endtask : rdc

  // cycles across n basic pulses, skipping the first to let a new setting land
  task automatic span(input int c, input int n);
    int k;
    int t0;
    k = 0;
    t0 = 0;
    repeat (n + 2)
    begin
      @(negedge clk_in);
      while (basic[c] !== 1'b1)
        @(negedge clk_in);
      k++;
      if (k == 2)
        t0 = cyc;
    end
    t = cyc - t0;
  endtask : span

  task automatic clr();
    repeat (4) @(posedge clk_in);
    bcnt = '{0, 0, 0};
    kcnt = '{0, 0, 0};
  endtask : clr

  task automatic cnt(input int c, input int b, input int k);
    repeat (4) @(posedge clk_in);
    chk(bcnt[c], b);
    chk(kcnt[c], k);
  endtask : cnt

  task automatic pulses(input int n);
    repeat (n)
    begin
      tmr <= 1'b1;
      @(posedge clk_in);
      tmr <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask : pulses

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0001);
    rdc(8'h18, 32'h0000_0000);
    rdc(8'h30, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    chk(err_q, 1'b1);
    done("registers");
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h04, {24'h00_0000, bcv[i]});
      span(0, 2);
      chk(t, bsp[i]);
    end
    chk(oe_n[0], 1'b0);
    wr(8'h30, 32'h0000_0001);
    wr(8'h04, 32'h0000_0001);
    span(0, 2);
    chk(t, 32);
    wr(8'h30, 32'h0000_0000);
    done("divider");
    wr(8'h00, 32'h0000_0002);
    wr(8'h08, 32'h0000_0007);
    wr(8'h04, 32'h0000_0043);
    span(0, 16);
    chk(t, 228);
    rdc(8'h0c, 32'h0000_0003);
    done("fraction");
    wr(8'h10, 32'h0000_0012);
    clr();
    repeat (60) @(posedge clk_in);
    cnt(1, 64, 4);
    wr(8'h20, 32'h0000_0021);
    clr();
    pulses(32);
    cnt(2, 32, 2);
    wr(8'h20, 32'h0000_0024);
    clr();
    pulses(8);
    cnt(2, 0, 0);
    done("sources");
    wr(8'h00, 32'h0000_0011);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd_q[0], 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, {24'h00_0000, pv[i]});
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk(rd_q[3:2], pe[i]);
    end
    chk(rd_q[0], 1'b1);
    done("status");
    wr(8'h00, 32'h0000_0032);
    clr();
    g[0].peer.run(4, 32);
    cnt(0, 32, 2);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd_q[4], 1'b0);
    g[0].peer.run(1, 8);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd_q[4], 1'b1);
    wr(8'h0c, 32'h0000_0010);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd_q[4], 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, i ? 32'h0000_000c : 32'h0000_0004);
      clr();
      chk(oe_n[0], 1'b1);
      g[0].peer.run(8, 16);
      cnt(0, 16, 16);
    end
    g[0].peer.run(2, 4);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd_q[4], 1'b1);
    done("pin clock");
    tally_and_finish();
  end
endmodule : test_serial_channel_clock_gen
